// ===== rtl/panel_timing_pkg.sv
package panel_timing_pkg;
  // system clock
  localparam int CLK_PERIOD_PS = 10000;
  // pixel clock is the system clock divided by this (50 MHz sits inside 44.58..59.37 MHz)
  localparam int PIX_DIV = 2;
  localparam int PIX_PERIOD_PS = CLK_PERIOD_PS * PIX_DIV;
  // horizontal timing in pixel clocks
  localparam int LINE_TOTAL = 1626;
  localparam int LINE_SYNC_W = 5;
  localparam int LINE_BACK_GAP = 100;
  localparam int LINE_ACTIVE_SPAN = 1440;
  localparam int LINE_FRONT_GAP = 86;
  // vertical timing in lines
  localparam int FRAME_TOTAL = 555;
  localparam int FRAME_SYNC_W = 2;
  localparam int FRAME_BACK_GAP = 8;
  localparam int FRAME_ACTIVE_SPAN = 540;
  localparam int FRAME_FRONT_GAP = 7;
  // pixel format
  localparam int COLOR_BITS = 8;
  localparam int PIXEL_BITS = 3 * COLOR_BITS;
  // serial link
  localparam int SLOTS = 7;
  localparam int PAIRS = 4;
  localparam int LINK_BITS = SLOTS * PAIRS;
  localparam logic [6:0] SER_CLOCK_SLOTS = 7'h78;
  localparam logic [PIXEL_BITS-1:0] PIXEL_BLACK = 24'h000000;
endpackage : panel_timing_pkg

// ===== rtl/span_counter.sv
`timescale 1ns/1ps
module span_counter #(
  parameter int TOTAL = 1626,
  parameter int SYNC_W = 5,
  parameter int START = 100,
  parameter int SPAN = 1440,
  parameter int W = 11
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic step,
  output logic [W-1:0] count,
  output logic wrap,
  output logic sync_nxt,
  output logic active_nxt
);
  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;
  localparam logic [W-1:0] LAST = W'(TOTAL - 1);
  localparam logic [W-1:0] SYNC_END = W'(SYNC_W);
  localparam logic [W-1:0] ACT_BEGIN = W'(START);
  localparam logic [W-1:0] ACT_END = W'(START + SPAN);

  assign wrap = (count_r == LAST);
  assign count_nxt = wrap ? '0 : count_r + W'(1);
  assign count = count_r;
  // levels for the position the counter moves to on this step
  assign sync_nxt = step ? (count_nxt < SYNC_END) : (count_r < SYNC_END);
  assign active_nxt = step ? ((count_nxt >= ACT_BEGIN) && (count_nxt < ACT_END))
                           : ((count_r >= ACT_BEGIN) && (count_r < ACT_END));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      // last position, so the first step lands on position 0 with a full sync
      count_r <= LAST;
    end else if (step) begin
      count_r <= count_nxt;
    end
  end
endmodule : span_counter

// ===== rtl/panel_timing_host.sv
// Contract
// - pixel clock near 54.15 MHz, kept within 44.58 to 59.37 MHz; this host runs 50 MHz.
// - pixel clock runs constant and gap-free while operating; this host stalls it while clk_en is low.
// - every line is exactly 1626 pixel clocks long.
// - line sync active for 5 clocks at line start.
// - every frame is 555 lines long.
// - frame sync active for 2 lines at frame start.
// - data-enable high for exactly 1440 clocks per active line.
// - 86 clock front gap between last pixel and next line sync.
// - first active pixel 100 clocks after line sync start.
// - frame sync edge within 10 clocks of line sync edge.
// - 7 line front gap between last active line and frame sync.
// - 540 active lines per frame, data-enable in each.
// - seven bit slots per forwarded clock period on each pair.
// - forwarded clock period 16.84 to 22.43 ns, tracking pixel clock.
// - line rate is 1/line period; frame rate adds lines per frame.
// - 24-bit pixel, 8 bits per colour, zeros black, ones full.
// - link is four data pairs plus one clock pair.
`timescale 1ns/1ps
module panel_timing_host
  import panel_timing_pkg::*;
#(
  parameter int H_W = 11,
  parameter int V_W = 10
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [PIXEL_BITS-1:0] pixel_in,
  output logic pixel_taken,
  output logic frame_start,
  output logic pixel_clock,
  output logic line_sync,
  output logic frame_sync,
  output logic pixel_valid_window,
  output logic [PIXEL_BITS-1:0] pixel_data,
  output logic [LINK_BITS-1:0] serial_slots,
  output logic [SLOTS-1:0] serial_clock_slots
);
  // two-phase divider: PH_HIGH is the half in which pixel_clock is high;
  // a PIX_DIV other than 2 would need more phases, so the package holds it fixed
  typedef enum logic [1:0] {
    PH_LOW = 2'b01,
    PH_HIGH = 2'b10
  } phase_t;

  phase_t phase_r;
  phase_t phase_nxt;
  logic tick;
  logic h_step;
  logic v_step;
  logic h_wrap;
  logic v_wrap;
  logic h_sync_nxt;
  logic v_sync_nxt;
  logic h_act_nxt;
  logic v_act_nxt;
  logic de_nxt;
  logic frame_start_nxt;
  logic [PIXEL_BITS-1:0] pixel_nxt;
  logic [LINK_BITS-1:0] slots_nxt;
  logic [SLOTS-1:0] ctrl_slots;

  // lower pairs carry pixel bits only; the last pair carries controls and the top bits
  localparam int DATA_BITS = (PAIRS - 1) * SLOTS;
  localparam int TOP_BITS = PIXEL_BITS - DATA_BITS;

  logic pixel_clock_r;
  logic line_sync_r;
  logic frame_sync_r;
  logic de_r;
  logic taken_r;
  logic frame_start_r;
  logic [PIXEL_BITS-1:0] pixel_r;
  logic [LINK_BITS-1:0] slots_r;
  logic [SLOTS-1:0] clock_slots_r;

  always_comb begin
    case (phase_r)
      PH_LOW: phase_nxt = PH_HIGH;
      PH_HIGH: phase_nxt = PH_LOW;
      // an illegal one-hot code falls back to the low phase
      default: phase_nxt = PH_LOW;
    endcase
  end
  // outputs change on the falling pixel clock edge, panel samples on the rising one
  // one tick per pixel clock; the sync, window, data and slot flops below are enabled by it
  assign tick = clk_en && (phase_r == PH_HIGH);

  // both counters leave reset on their last position, so the first tick
  // opens line 0 of frame 0 with full sync widths and a full first line
  // horizontal counter
  // the line counter advances once per pixel clock
  assign h_step = tick;
  span_counter #(
    .TOTAL(LINE_TOTAL),
    .SYNC_W(LINE_SYNC_W),
    .START(LINE_BACK_GAP),
    .SPAN(LINE_ACTIVE_SPAN),
    .W(H_W)
  ) u_line (
    .clk(clk),
    .reset_n(reset_n),
    .step(h_step),
    .count(),
    .wrap(h_wrap),
    .sync_nxt(h_sync_nxt),
    .active_nxt(h_act_nxt)
  );

  // rates follow from the totals: a line is LINE_TOTAL pixel clocks and
  // a frame FRAME_TOTAL lines; at a 50 MHz pixel clock the frame rate lands
  // near 55 Hz, under the 60 Hz nominal that wants the faster pixel clock
  // vertical counter steps at line wrap
  // both syncs rise on the same tick, skew zero
  assign v_step = tick && h_wrap;
  span_counter #(
    .TOTAL(FRAME_TOTAL),
    .SYNC_W(FRAME_SYNC_W),
    .START(FRAME_BACK_GAP),
    .SPAN(FRAME_ACTIVE_SPAN),
    .W(V_W)
  ) u_frame (
    .clk(clk),
    .reset_n(reset_n),
    .step(v_step),
    .count(),
    .wrap(v_wrap),
    .sync_nxt(v_sync_nxt),
    .active_nxt(v_act_nxt)
  );

  // data-enable only inside both active spans
  // de_nxt looks ahead to the position the counters move to on this tick
  assign de_nxt = h_act_nxt && v_act_nxt;
  // blanking carries black so stale data never leaks
  // pixel_in is read only on a tick inside the window; in blanking it is dropped
  assign pixel_nxt = de_nxt ? pixel_in : PIXEL_BLACK;
  // frame_start marks the tick that opens line 0 of a frame
  assign frame_start_nxt = v_step && v_wrap;

  // seven slots per pair, four pairs
  // the slot map inside a pair is our own; the serialiser must share it
  assign ctrl_slots = {1'b0, de_nxt, v_sync_nxt, h_sync_nxt,
                       pixel_nxt[PIXEL_BITS-1 -: TOP_BITS]};

  genvar gp;
  generate
    for (gp = 0; gp < PAIRS; gp++) begin : g_pair
      localparam int LO = gp * SLOTS;
      if (gp < PAIRS - 1) begin : g_data
        assign slots_nxt[LO +: SLOTS] = pixel_nxt[LO +: SLOTS];
      end else begin : g_ctrl
        assign slots_nxt[LO +: SLOTS] = ctrl_slots;
      end
    end
  endgenerate

  // divider flops; clk_en low holds the phase, so the pixel clock stalls
  // with it rather than running on unrelated to the frozen counters
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_r <= PH_LOW;
      pixel_clock_r <= 1'b0;
    end else if (clk_en) begin
      phase_r <= phase_nxt;
      // pixel_clock rises on the edge after a tick and falls on the tick itself
      pixel_clock_r <= (phase_nxt == PH_HIGH);
    end
  end

  // timing outputs move only on a tick, one pixel clock apart
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      line_sync_r <= 1'b0;
      frame_sync_r <= 1'b0;
      de_r <= 1'b0;
      pixel_r <= PIXEL_BLACK;
      slots_r <= '0;
    end else if (tick) begin
      line_sync_r <= h_sync_nxt;
      frame_sync_r <= v_sync_nxt;
      de_r <= de_nxt;
      pixel_r <= pixel_nxt;
      slots_r <= slots_nxt;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      taken_r <= 1'b0;
      frame_start_r <= 1'b0;
      clock_slots_r <= '0;
    end else if (clk_en) begin
      // pixel_taken asks the source for the next pixel, due within two clk cycles
      taken_r <= tick && de_nxt;
      frame_start_r <= frame_start_nxt;
      // four high slots then three low
      // zero out of reset, so no serial clock shows before the first enable
      clock_slots_r <= SER_CLOCK_SLOTS;
    end
  end

  // every output is the flop behind it, so the serialiser sees no glitches
  assign pixel_clock = pixel_clock_r;
  assign line_sync = line_sync_r;
  assign frame_sync = frame_sync_r;
  assign pixel_valid_window = de_r;
  assign pixel_data = pixel_r;
  assign pixel_taken = taken_r;
  assign frame_start = frame_start_r;
  assign serial_slots = slots_r;
  assign serial_clock_slots = clock_slots_r;
endmodule : panel_timing_host

// ===== tb/panel_sink.sv
`timescale 1ns/1ps
module panel_sink
  import panel_timing_pkg::*;
(
  input wire logic clk,
  input wire logic pixel_clock,
  input wire logic frame_sync,
  input wire logic pixel_valid_window,
  input wire logic [PIXEL_BITS-1:0] pixel_data,
  output int line_px,
  output int rows,
  output logic [PIXEL_BITS-1:0] first_px
);
  logic pc_d = 1'b0;
  int col = 0;
  initial line_px = 0;
  initial rows = 0;
  // latch on the rising pixel clock, where the data has settled
  always @(posedge clk) begin
    pc_d <= pixel_clock;
    if (pixel_clock && !pc_d) begin
      if (pixel_valid_window) begin
        if (col == 0) first_px <= pixel_data;
        col <= col + 1;
      end else if (col != 0) begin
        line_px <= col;
        rows <= rows + 1;
        col <= 0;
      end
      if (frame_sync) rows <= 0;
    end
  end
endmodule : panel_sink

// ===== tb/panel_timing_host_props.sv
`timescale 1ns/1ps
module panel_timing_host_props
  import panel_timing_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic pixel_clock,
  input wire logic line_sync,
  input wire logic frame_sync,
  input wire logic pixel_valid_window,
  input wire logic [PIXEL_BITS-1:0] pixel_data,
  input wire logic [SLOTS-1:0] serial_clock_slots
);
  int hc_r;
  logic seen_r;
  // clk cycles since line sync rose; seen_r hides the count from reset to the first line sync
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hc_r <= 0;
      seen_r <= 1'b0;
    end else begin
      hc_r <= $rose(line_sync) ? 0 : hc_r + 1;
      seen_r <= seen_r | $rose(line_sync);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_pclk; clk_en |=> pixel_clock != $past(pixel_clock); endproperty
  a_pclk: assert property (p_pclk) else $error("pixel clock stopped");
  property p_line; $rose(line_sync) && seen_r |-> hc_r == 3251; endproperty
  a_line: assert property (p_line) else $error("line length wrong");
  property p_hsw; $fell(line_sync) |-> hc_r == 9; endproperty
  a_hsw: assert property (p_hsw) else $error("line sync width wrong");
  property p_bp; $rose(pixel_valid_window) |-> seen_r && hc_r == 199; endproperty
  a_bp: assert property (p_bp) else $error("back gap wrong");
  property p_de; $fell(pixel_valid_window) |-> hc_r == 3079; endproperty
  a_de: assert property (p_de) else $error("active span wrong");
  property p_skew; $rose(frame_sync) |-> $rose(line_sync) || hc_r < 20; endproperty
  a_skew: assert property (p_skew) else $error("sync skew too big");
  property p_blank; !pixel_valid_window |-> pixel_data == PIXEL_BLACK; endproperty
  a_blank: assert property (p_blank) else $error("data outside window");
  property p_sclk; pixel_valid_window |-> serial_clock_slots == SER_CLOCK_SLOTS; endproperty
  a_sclk: assert property (p_sclk) else $error("serial clock shape");
endmodule : panel_timing_host_props
bind panel_timing_host panel_timing_host_props panel_timing_host_props_inst (.clk, .reset_n,
  .clk_en, .pixel_clock, .line_sync, .frame_sync, .pixel_valid_window, .pixel_data,
  .serial_clock_slots);

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench
  import panel_timing_pkg::*;
;
  logic clk, reset_n, clk_en, pixel_clock, line_sync, frame_sync, pixel_valid_window, ls_d;
  logic pixel_taken, frame_start;
  logic [PIXEL_BITS-1:0] pixel_in, pixel_data, first_px;
  logic [LINK_BITS-1:0] serial_slots;
  logic [SLOTS-1:0] serial_clock_slots;
  int errors, tests_run, line_px, rows, n;
  int nls = 0;
  int nfs = 0;
  // rows: {pixel_in, pixel shown}; blue high, red low
  logic [47:0] tbl [5] = '{48'h000000_000000, 48'h0000FF_0000FF, 48'h00FF00_00FF00,
    48'hFF0000_FF0000, 48'hFFFFFF_FFFFFF};
  panel_timing_host panel_timing_host_inst (.clk, .reset_n, .clk_en, .pixel_in,
    .pixel_taken, .frame_start, .pixel_clock, .line_sync, .frame_sync,
    .pixel_valid_window, .pixel_data, .serial_slots, .serial_clock_slots);
  panel_sink panel_sink_inst (.clk, .pixel_clock, .frame_sync, .pixel_valid_window,
    .pixel_data, .line_px, .rows, .first_px);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    ls_d <= line_sync;
    if (line_sync && !ls_d) begin
      nls <= nls + 1;
      nfs <= nfs + frame_sync;
    end
  end
  task finish_test;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  task chk(string nm, logic [31:0] e, logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task wait_de(logic v);
    for (n = 0; n < 40000 && pixel_valid_window !== v; n++) begin
      @(posedge clk);
      #1;
    end
    if (n == 40000) begin
      errors++;
      finish_test();
    end
  endtask : wait_de
  initial begin
    errors = 0;
    tests_run = 0;
    reset_n = 1'b0;
    clk_en = 1'b1;
    pixel_in = tbl[0][47:24];
    repeat (12) @(posedge clk);
    #1;
    chk("syncs in reset", 0, {frame_sync, line_sync, pixel_valid_window});
    reset_n = 1'b1;
    wait_de(1'b1);
    // syncs of lines 0..8 are seen once line 8 turns active
    chk("lines to first active", 9, nls);
    chk("frame sync lines", 2, nfs);
    for (int i = 0; i < 5; i++) begin
      wait_de(1'b1);
      chk("pixel_data", tbl[i][23:0], pixel_data);
      chk("pixel_taken", 1, pixel_taken);
      // last pair: {0, window, frame sync, line sync}, then the top pixel bits
      chk("serial_slots", {4'h4, tbl[i][23:0]}, serial_slots);
      chk("serial_clock_slots", SER_CLOCK_SLOTS, serial_clock_slots);
      wait_de(1'b0);
      repeat (6) @(posedge clk);
      #1;
      chk("first pixel", tbl[i][23:0], first_px);
      chk("pixels per line", 1440, line_px);
      chk("active rows", i + 1, rows);
      pixel_in = tbl[(i + 1) % 5][47:24];
    end
    @(posedge clk);
    #1;
    pixel_in = tbl[4][47:24];
    wait_de(1'b1);
    chk("pixel before reset", tbl[4][23:0], pixel_data);
    reset_n = 1'b0;
    #1;
    chk("data in reset", 0, pixel_data);
    chk("in reset", 0, {pixel_taken, frame_sync, line_sync, pixel_valid_window});
    clk_en = 1'b0;
    @(posedge clk);
    #1;
    reset_n = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk("stalled pixel clock", 0, pixel_clock);
    clk_en = 1'b1;
    @(posedge clk);
    #1;
    chk("pixel clock after enable", 1, pixel_clock);
    @(posedge clk);
    #1;
    // first tick opens line 0 of frame 0 with both syncs
    chk("first tick", 4'hE, {frame_start, frame_sync, line_sync, pixel_valid_window});
    finish_test();
  end
endmodule : testbench
